// File: bench/scs_checker.sv
// Port assertions of the speed command sequencer.
// Assumes it is bound to scs_speed_sequencer and sees only its ports.
`timescale 1ns/100ps
module scs_checker
  import scs_pkg::*;
#(
  parameter int MS_CYCLES_P = 10
)
(
  input logic clk,
  input logic rst_n,
  input scs_apb_req_t apb_req,
  input scs_apb_rsp_t apb_rsp,
  input scs_pins_t pins,
  input logic [SCS_SPD_W-1:0] aux_ext_speed,
  input scs_cmd_t cmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // Assertions
  // ****************
  pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready high for more than one cycle");
  pready_due_a: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |-> ##[1:2] apb_rsp.pready)
    else $error("pready did not come");
  mapped_ok_a: assert property (apb_rsp.pready && apb_req.paddr < 12'h028 |-> !apb_rsp.pslverr)
    else $error("error response on a mapped register");
  ramp_range_a: assert property (cmd.ramp <= SCS_RAMP_MAX)
    else $error("ramp set out of range");
  ramp_idle_a: assert property (!cmd.running |-> cmd.ramp == 3'h0)
    else $error("ramp set while not running");
  stop_quiet_a: assert property (cmd.stopped |-> cmd.speed == 16'h0000 && !cmd.running)
    else $error("speed not zero after stop");
  run_excl_a: assert property (cmd.running |-> !cmd.stopped)
    else $error("running and stopped together");
  no_min_a: assert property (cmd.speed != SCS_SPD_ILLEGAL)
    else $error("speed outside signed limit");
  disable_clr_a: assert property ($fell(pins.servo_enable) |-> ##[2:10] (cmd.stage == 4'h0 && !cmd.stopped))
    else $error("sequencer not cleared on disable");
  cover property (apb_rsp.pready && apb_rsp.pslverr);
  cover property (cmd.stopped);
  cover property (cmd.running && cmd.stage == 4'h5);
endmodule
bind scs_speed_sequencer scs_checker #(.MS_CYCLES_P(MS_CYCLES_P)) i_scs_checker (.clk(clk), .rst_n(rst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .pins(pins), .aux_ext_speed(aux_ext_speed), .cmd(cmd));

// File: bench/scs_pin_model.sv
// Input terminals model: enable, A/B switch and stage terminals.
// Assumes requests change just after a clk edge; pins follow one clock later.
`timescale 1ns/100ps
module scs_pin_model
  import scs_pkg::*;
(
  input logic clk,
  input logic en_req,
  input logic sw_req,
  input logic [SCS_STG_W-1:0] stg_req,
  output scs_pins_t pins
);
  initial pins = '0;
  // Terminals carry the stage number as a plain binary value
  always @(posedge clk) begin
    pins <= '{servo_enable: en_req, ab_switch: sw_req, stage_terms: stg_req};
  end
endmodule

// File: bench/tb.sv
// Self-checking bench of the speed command sequencer over APB and pins.
// Assumes MS_CYCLES_P of 10 so that a millisecond is ten clocks.
`timescale 1ns/100ps
module tb;
  import scs_pkg::*;
  logic clk;
  logic rst_n;
  logic en;
  logic sw;
  logic [3:0] stg;
  logic [15:0] aux;
  logic [31:0] q;
  logic e;
  scs_apb_req_t req;
  scs_apb_rsp_t rsp;
  scs_pins_t pins;
  scs_cmd_t cmd;
  int num_errors;
  int n_checks;
  scs_pin_model i_scs_pin_model (.clk(clk), .en_req(en), .sw_req(sw), .stg_req(stg), .pins(pins));
  scs_speed_sequencer #(.MS_CYCLES_P(10)) i_scs_speed_sequencer (.clk(clk), .rst_n(rst_n), .apb_req(req),
    .apb_rsp(rsp), .pins(pins), .aux_ext_speed(aux), .cmd(cmd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  // Holds the request until pready is sampled, then idles one cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic spd(input logic [15:0] x);
    repeat (12) @(posedge clk);
    chk("speed", {16'h0000, x}, {16'h0000, cmd.speed});
  endtask
  task automatic wt(input logic [3:0] s, input logic sp);
    int n;
    n = 0;
    while ((sp ? cmd.stopped !== 1'b1 : (cmd.stage !== s || cmd.running !== 1'b1)) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      num_errors++;
      give_verdict();
    end
    repeat (3) @(posedge clk);
    chk("stage", {28'h0, s}, {28'h0, cmd.stage});
    chk("stopped", {31'h0, sp}, {31'h0, cmd.stopped});
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    logic [11:0] a[5] = '{SCS_OFS_PRI, SCS_OFS_SEC_SRC, SCS_OFS_SEC, SCS_OFS_COMM, SCS_OFS_MODE};
    logic [31:0] x[5] = '{32'h0000_01f4, 32'h0000_0000, 32'h0000_01f4, 32'h0000_0000, 32'h0000_0000};
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0000_0000);
      chk("reset value", x[i], q);
    end
    apb(1'b1, 12'h030, 32'h0000_0001);
    chk("slverr", 32'h0000_0001, {31'h0, e});
    $display("test regs done");
  endtask
  task automatic t_src;
    apb(1'b1, SCS_OFS_PRI, 32'hffff_ff9c);
    apb(1'b0, SCS_OFS_PRI, 32'h0000_0000);
    chk("primary", 32'hffff_ff9c, q);
    apb(1'b1, SCS_OFS_SEC, 32'h0000_8000);
    apb(1'b0, SCS_OFS_SEC, 32'h0000_0000);
    chk("secondary", 32'hffff_8001, q);
    apb(1'b1, SCS_OFS_COMM, 32'h0000_0064);
    spd(16'hff9c);
    apb(1'b1, SCS_OFS_SRC, 32'h0000_0001);
    spd(16'h8001);
    apb(1'b1, SCS_OFS_SRC, 32'h0000_0002);
    spd(16'hff9c);
    sw <= 1'b1;
    spd(16'h8001);
    sw <= 1'b0;
    apb(1'b1, SCS_OFS_SRC, 32'h0000_0003);
    spd(16'h8001);
    apb(1'b1, SCS_OFS_SRC, 32'h0000_0004);
    spd(16'h0064);
    aux <= 16'h0123;
    apb(1'b1, SCS_OFS_SEC_SRC, 32'h0000_0001);
    apb(1'b1, SCS_OFS_SRC, 32'h0000_0001);
    spd(16'h0123);
    apb(1'b1, SCS_OFS_SRC, 32'h0000_0006);
    spd(16'h0000);
    $display("test sources done");
  endtask
  task automatic t_single;
    apb(1'b1, 12'h100, 32'h0000_0064);
    apb(1'b1, 12'h104, 32'h0001_0003);
    apb(1'b1, 12'h108, 32'h0000_00c8);
    apb(1'b1, 12'h10c, 32'h0004_0003);
    apb(1'b0, 12'h10c, 32'h0000_0000);
    chk("stage param", 32'h0004_0003, q);
    apb(1'b1, SCS_OFS_COUNT, 32'h0000_0002);
    apb(1'b1, SCS_OFS_UNIT, 32'h0000_0000);
    apb(1'b1, SCS_OFS_SRC, 32'h0000_0005);
    en <= 1'b1;
    wt(4'h0, 1'b0);
    chk("speed", 32'h0000_0064, {16'h0000, cmd.speed});
    chk("ramp", 32'h0000_0001, {29'h0, cmd.ramp});
    apb(1'b1, SCS_OFS_MODE, 32'h0000_0001);
    apb(1'b0, SCS_OFS_MODE, 32'h0000_0000);
    chk("mode", 32'h0000_0000, q);
    wt(4'h1, 1'b0);
    chk("ramp", 32'h0000_0004, {29'h0, cmd.ramp});
    wt(4'h1, 1'b1);
    spd(16'h0000);
    en <= 1'b0;
    repeat (12) @(posedge clk);
    chk("stage", 32'h0000_0000, {28'h0, cmd.stage});
    $display("test single done");
  endtask
  task automatic t_loop;
    apb(1'b1, SCS_OFS_MODE, 32'h0000_0001);
    en <= 1'b1;
    wt(4'h0, 1'b0);
    wt(4'h1, 1'b0);
    wt(4'h0, 1'b0);
    chk("speed", 32'h0000_0064, {16'h0000, cmd.speed});
    en <= 1'b0;
    repeat (12) @(posedge clk);
    $display("test loop done");
  endtask
  task automatic t_term;
    apb(1'b1, 12'h118, 32'h0000_014d);
    apb(1'b1, 12'h128, 32'h0000_fe0c);
    apb(1'b1, SCS_OFS_MODE, 32'h0000_0003);
    apb(1'b0, SCS_OFS_MODE, 32'h0000_0000);
    chk("mode", 32'h0000_0001, q);
    apb(1'b1, SCS_OFS_MODE, 32'h0000_0002);
    stg <= 4'h3;
    en <= 1'b1;
    wt(4'h3, 1'b0);
    chk("speed", 32'h0000_014d, {16'h0000, cmd.speed});
    stg <= 4'h5;
    wt(4'h5, 1'b0);
    chk("speed", 32'h0000_fe0c, {16'h0000, cmd.speed});
    apb(1'b0, SCS_OFS_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0555, q);
    en <= 1'b0;
    $display("test terminals done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #160000;
    num_errors++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    en = 1'b0;
    sw = 1'b0;
    stg = 4'h0;
    aux = 16'h0000;
    req = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_src();
    t_single();
    t_loop();
    t_term();
    give_verdict();
  end
endmodule

// File: pkg/scs_pkg.sv
// Constants, types and register map of the speed command sequencer.
// Assumes a 125 MHz clock and an APB master with 32-bit data and 12-bit byte addresses.
package scs_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int SCS_DATA_W = 32;
  localparam int SCS_ADDR_W = 12;
  localparam int SCS_SPD_W = 16;
  localparam int SCS_TIME_W = 15;
  localparam int SCS_RAMP_W = 3;
  localparam int SCS_STAGES = 16;
  localparam int SCS_STG_W = 4;
  localparam int SCS_CNT_W = 5;
  localparam int SCS_MS_CNT_W = 17;
  localparam int SCS_S_CNT_W = 10;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_SRC = 12'h000;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_PRI = 12'h004;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_SEC_SRC = 12'h008;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_SEC = 12'h00c;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_COMM = 12'h010;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_MODE = 12'h014;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_COUNT = 12'h018;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_UNIT = 12'h01c;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_STATUS = 12'h020;
  localparam logic [SCS_ADDR_W-1:0] SCS_OFS_SPEED = 12'h024;
  // Stage table: 0x100 + 8*stage, word 0 speed, word 1 time and ramp
  localparam logic [4:0] SCS_STG_REGION = 5'h02;
  localparam int SCS_STG_REGION_LO = 7;
  localparam int SCS_STG_IDX_LO = 3;
  localparam int SCS_STG_WORD_BIT = 2;
  localparam int SCS_RAMP_LO = 16;

  // ************************************************************
  // Status fields
  // ************************************************************
  localparam int SCS_STAT_STAGE_LO = 0;
  localparam int SCS_STAT_RUN_BIT = 4;
  localparam int SCS_STAT_DONE_BIT = 5;
  localparam int SCS_STAT_EN_BIT = 6;
  localparam int SCS_STAT_SW_BIT = 7;
  localparam int SCS_STAT_TERM_LO = 8;

  // ************************************************************
  // Reset values and limits
  // ************************************************************
  localparam logic [SCS_SPD_W-1:0] SCS_RST_PRI = 16'h01f4;
  localparam logic [SCS_SPD_W-1:0] SCS_RST_SEC = 16'h01f4;
  localparam logic [SCS_SPD_W-1:0] SCS_RST_COMM = 16'h0000;
  localparam logic [SCS_SPD_W-1:0] SCS_RST_SEC_SRC = 16'h0000;
  localparam logic [SCS_CNT_W-1:0] SCS_RST_COUNT = 5'h10;
  localparam logic SCS_RST_UNIT = 1'h1;
  localparam logic [SCS_TIME_W-1:0] SCS_RST_STG_TIME = 15'h000a;
  localparam logic [SCS_SPD_W-1:0] SCS_SPD_MAX = 16'h7fff;
  localparam logic [SCS_SPD_W-1:0] SCS_SPD_MIN = 16'h8001;
  localparam logic [SCS_SPD_W-1:0] SCS_SPD_ILLEGAL = 16'h8000;
  localparam logic [SCS_SPD_W-1:0] SCS_SEC_SRC_DIGITAL = 16'h0000;
  localparam logic [SCS_SPD_W-1:0] SCS_SEC_SRC_MAX = 16'h0004;
  localparam logic [SCS_SPD_W-1:0] SCS_MODE_MAX = 16'h0002;
  localparam logic [SCS_SPD_W-1:0] SCS_COUNT_MIN = 16'h0001;
  localparam logic [SCS_SPD_W-1:0] SCS_COUNT_MAX = 16'h0010;
  localparam logic [SCS_RAMP_W-1:0] SCS_RAMP_MAX = 3'h4;
  localparam logic [SCS_TIME_W-1:0] SCS_TIME_MAX = 15'h7fff;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int SCS_CLK_PERIOD_NS = 8;
  localparam int SCS_MS_NS = 1000000;
  localparam int SCS_MS_CYCLES = SCS_MS_NS / SCS_CLK_PERIOD_NS;
  localparam int SCS_S_MS = 1000;
  localparam logic [SCS_S_CNT_W-1:0] SCS_S_LAST = SCS_S_CNT_W'(SCS_S_MS - 1);

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [2:0] {
    SRC_PRI = 3'h0, SRC_SEC = 3'h1, SRC_SWITCH = 3'h2, SRC_SUM = 3'h3,
    SRC_COMM = 3'h4, SRC_MULTI = 3'h5, SRC_UPDOWN = 3'h6, SRC_SINE = 3'h7
  } scs_src_t;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0, MODE_LOOP = 2'h1, MODE_TERM = 2'h2
  } scs_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_DONE = 3'b100
  } scs_seq_st_t;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [SCS_ADDR_W-1:0] paddr;
    logic [SCS_DATA_W-1:0] pwdata;
  } scs_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [SCS_DATA_W-1:0] prdata;
    logic pslverr;
  } scs_apb_rsp_t;

  typedef struct packed {
    logic [SCS_RAMP_W-1:0] ramp;
    logic [SCS_TIME_W-1:0] run_time;
    logic [SCS_SPD_W-1:0] speed;
  } scs_stage_t;

  typedef struct packed {
    logic servo_enable;
    logic ab_switch;
    logic [SCS_STG_W-1:0] stage_terms;
  } scs_pins_t;

  typedef struct packed {
    logic [SCS_SPD_W-1:0] speed;
    logic [SCS_RAMP_W-1:0] ramp;
    logic [SCS_STG_W-1:0] stage;
    logic running;
    logic stopped;
  } scs_cmd_t;

  localparam scs_stage_t SCS_RST_STAGE = '{ramp: 3'h0, run_time: SCS_RST_STG_TIME, speed: 16'h0000};

endpackage

// File: src/scs_speed_sequencer.sv
// Speed command selection and multi-stage speed sequencer with an APB register slave.
// Assumes the enable, switch and stage pins are asynchronous and aux_ext_speed is on clk.
//
// What this block does
// (R1) Primary and secondary speeds are either added or switched, as the source selection says.
// (R2) With the switch input active the secondary speed is used, otherwise the primary.
// (R3) The sequencer has three modes: single pass then stop, loop, and stage from terminals.
// (R4) Mode code 0 is single pass, 1 loop, 2 terminal, default 0, writable only while disabled.
// (R5) The mode only acts in speed control when the source is the multi-stage sequencer.
// (R6) In single pass the sequencer starts at stage one on enable and steps on as stages complete.
// (R7) In single pass the motor stops once the stage equal to the stage count has completed.
// (R8) In loop mode the last stage is followed by stage one again, without end.
// (R9) In terminal mode the terminal value read after enable selects the stage to run.
// (R10) In terminal mode a change of the terminals selects the new stage at once.
// (R11) Each stage has its own signed speed, output while that stage is active.
// (R12) Each stage has its own run time, after which the sequencer moves on.
// (R13) Each stage selects one of five ramp sets, zero being the default speed ramp.
// (R14) The digital setpoints are signed 16-bit rpm values limited to plus or minus 32767.
// (R15) A disabled motor returns the sequencer to stage one with its elapsed time cleared.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
module scs_speed_sequencer
  import scs_pkg::*;
#(
  parameter int MS_CYCLES_P = SCS_MS_CYCLES
)
(
  input logic clk,
  input logic rst_n,
  input scs_apb_req_t apb_req,
  output scs_apb_rsp_t apb_rsp,
  input scs_pins_t pins,
  input logic [SCS_SPD_W-1:0] aux_ext_speed,
  output scs_cmd_t cmd
);

  localparam logic [SCS_MS_CNT_W-1:0] MS_LAST = SCS_MS_CNT_W'(MS_CYCLES_P - 1);

  typedef struct packed {
    scs_pins_t s1;
    scs_pins_t s2;
    scs_pins_t s3;
    scs_pins_t filt;
    scs_apb_rsp_t rsp;
    scs_src_t src;
    logic [SCS_SPD_W-1:0] pri;
    logic [SCS_SPD_W-1:0] sec_src;
    logic [SCS_SPD_W-1:0] sec;
    logic [SCS_SPD_W-1:0] comm;
    scs_mode_t mode;
    logic [SCS_CNT_W-1:0] count;
    logic unit;
    scs_seq_st_t st;
    logic [SCS_STG_W-1:0] stage;
    logic [SCS_TIME_W-1:0] elapsed;
    logic settle;
    logic [SCS_MS_CNT_W-1:0] ms_cnt;
    logic [SCS_S_CNT_W-1:0] s_cnt;
    scs_cmd_t cmd;
  } scs_top_st_t;

  scs_top_st_t r;
  scs_top_st_t n;
  logic [1:0] rst_pipe_r;
  logic rst_sync_n;

  logic mem_wr_speed;
  logic mem_wr_param;
  scs_stage_t mem_wdata;
  scs_stage_t rd_stage;
  scs_stage_t cur_stage;
  logic [SCS_STG_W-1:0] bus_idx;

  // ************************************************************
  // Reset release
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'h1};
    end
  end

  assign rst_sync_n = rst_pipe_r[1];

  // ************************************************************
  // Stage table
  // ************************************************************
  assign bus_idx = apb_req.paddr[SCS_STG_IDX_LO +: SCS_STG_W];

  scs_stage_mem u_stage_mem (
    .clk(clk),
    .rst_n(rst_sync_n),
    .wr_speed(mem_wr_speed),
    .wr_param(mem_wr_param),
    .waddr(bus_idx),
    .wdata(mem_wdata),
    .raddr_a(bus_idx),
    .raddr_b(r.stage),
    .rdata_a(rd_stage),
    .rdata_b(cur_stage)
  );

  // Only -32768 lies outside the legal speed range
  function automatic logic [SCS_SPD_W-1:0] scs_clamp(input logic [SCS_SPD_W-1:0] v);
    scs_clamp = (v == SCS_SPD_ILLEGAL) ? SCS_SPD_MIN : v;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic en;
    logic sw;
    logic [SCS_STG_W-1:0] term;
    logic setup;
    logic access;
    logic stg_hit;
    logic reg_hit;
    logic do_wr;
    logic [SCS_DATA_W-1:0] rd_word;
    logic active;
    logic ms_tick;
    logic s_tick;
    logic unit_tick;
    logic last;
    logic [SCS_SPD_W-1:0] spd_b;
    logic [SCS_SPD_W:0] sum;
    logic [SCS_SPD_W-1:0] sum_sat;
    en = 1'h0;
    sw = 1'h0;
    term = '0;
    setup = 1'h0;
    access = 1'h0;
    stg_hit = 1'h0;
    reg_hit = 1'h0;
    do_wr = 1'h0;
    rd_word = '0;
    active = 1'h0;
    ms_tick = 1'h0;
    s_tick = 1'h0;
    unit_tick = 1'h0;
    last = 1'h0;
    spd_b = '0;
    sum = '0;
    sum_sat = '0;
    n = r;
    mem_wr_speed = 1'h0;
    mem_wr_param = 1'h0;
    mem_wdata.speed = scs_clamp(apb_req.pwdata[SCS_SPD_W-1:0]); // (R14)
    mem_wdata.run_time = apb_req.pwdata[SCS_TIME_W-1:0];
    mem_wdata.ramp = apb_req.pwdata[SCS_RAMP_LO +: SCS_RAMP_W];

    // Pins: a change counts once the second and third stages agree
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.filt = r.s3;
    end
    en = r.filt.servo_enable;
    sw = r.filt.ab_switch;
    term = r.filt.stage_terms;

    // APB: setup, one wait cycle, then pready
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    stg_hit = (apb_req.paddr[SCS_ADDR_W-1:SCS_STG_REGION_LO] == SCS_STG_REGION) && (apb_req.paddr[1:0] == 2'h0);
    unique case (apb_req.paddr)
      SCS_OFS_SRC: begin
        reg_hit = 1'h1;
        rd_word[2:0] = r.src;
      end
      SCS_OFS_PRI: begin
        reg_hit = 1'h1;
        rd_word = {{(SCS_DATA_W-SCS_SPD_W){r.pri[SCS_SPD_W-1]}}, r.pri};
      end
      SCS_OFS_SEC_SRC: begin
        reg_hit = 1'h1;
        rd_word[SCS_SPD_W-1:0] = r.sec_src;
      end
      SCS_OFS_SEC: begin
        reg_hit = 1'h1;
        rd_word = {{(SCS_DATA_W-SCS_SPD_W){r.sec[SCS_SPD_W-1]}}, r.sec};
      end
      SCS_OFS_COMM: begin
        reg_hit = 1'h1;
        rd_word = {{(SCS_DATA_W-SCS_SPD_W){r.comm[SCS_SPD_W-1]}}, r.comm};
      end
      SCS_OFS_MODE: begin
        reg_hit = 1'h1;
        rd_word[1:0] = r.mode;
      end
      SCS_OFS_COUNT: begin
        reg_hit = 1'h1;
        rd_word[SCS_CNT_W-1:0] = r.count;
      end
      SCS_OFS_UNIT: begin
        reg_hit = 1'h1;
        rd_word[0] = r.unit;
      end
      SCS_OFS_STATUS: begin
        reg_hit = 1'h1;
        rd_word[SCS_STAT_STAGE_LO +: SCS_STG_W] = r.stage;
        rd_word[SCS_STAT_RUN_BIT] = (r.st == ST_RUN);
        rd_word[SCS_STAT_DONE_BIT] = (r.st == ST_DONE);
        rd_word[SCS_STAT_EN_BIT] = en;
        rd_word[SCS_STAT_SW_BIT] = sw;
        rd_word[SCS_STAT_TERM_LO +: SCS_STG_W] = term;
      end
      SCS_OFS_SPEED: begin
        reg_hit = 1'h1;
        rd_word = {{(SCS_DATA_W-SCS_SPD_W){r.cmd.speed[SCS_SPD_W-1]}}, r.cmd.speed};
      end
      default: begin
        reg_hit = 1'h0;
      end
    endcase
    if (stg_hit) begin
      if (apb_req.paddr[SCS_STG_WORD_BIT]) begin
        rd_word[SCS_TIME_W-1:0] = rd_stage.run_time;
        rd_word[SCS_RAMP_LO +: SCS_RAMP_W] = rd_stage.ramp;
      end else begin
        rd_word = {{(SCS_DATA_W-SCS_SPD_W){rd_stage.speed[SCS_SPD_W-1]}}, rd_stage.speed};
      end
    end
    n.rsp.pready = access & ~r.rsp.pready;
    if (access && !r.rsp.pready) begin
      n.rsp.prdata = apb_req.pwrite ? '0 : rd_word;
      n.rsp.pslverr = ~(reg_hit | stg_hit);
    end else if (setup) begin
      n.rsp.pslverr = 1'h0;
    end
    do_wr = access & r.rsp.pready & apb_req.pwrite;

    // Register writes take effect at the edge that completes the transfer
    if (do_wr && reg_hit) begin
      unique case (apb_req.paddr)
        SCS_OFS_SRC: n.src = scs_src_t'(apb_req.pwdata[2:0]);
        SCS_OFS_PRI: n.pri = scs_clamp(apb_req.pwdata[SCS_SPD_W-1:0]); // (R14)
        SCS_OFS_SEC: n.sec = scs_clamp(apb_req.pwdata[SCS_SPD_W-1:0]); // (R14)
        SCS_OFS_COMM: n.comm = scs_clamp(apb_req.pwdata[SCS_SPD_W-1:0]); // (R14)
        SCS_OFS_SEC_SRC: begin
          if (apb_req.pwdata[SCS_SPD_W-1:0] <= SCS_SEC_SRC_MAX) begin
            n.sec_src = apb_req.pwdata[SCS_SPD_W-1:0];
          end
        end
        SCS_OFS_MODE: begin
          // A running sequence keeps its mode; the write is dropped
          if (!en && apb_req.pwdata[SCS_SPD_W-1:0] <= SCS_MODE_MAX) begin // (R4)
            n.mode = scs_mode_t'(apb_req.pwdata[1:0]); // (R4)
          end
        end
        SCS_OFS_COUNT: begin
          if (apb_req.pwdata[SCS_SPD_W-1:0] >= SCS_COUNT_MIN && apb_req.pwdata[SCS_SPD_W-1:0] <= SCS_COUNT_MAX) begin
            n.count = apb_req.pwdata[SCS_CNT_W-1:0];
          end
        end
        SCS_OFS_UNIT: n.unit = apb_req.pwdata[0];
        default: n.unit = r.unit;
      endcase
    end
    if (do_wr && stg_hit) begin
      mem_wr_speed = ~apb_req.paddr[SCS_STG_WORD_BIT]; // (R11)
      mem_wr_param = apb_req.paddr[SCS_STG_WORD_BIT] & (mem_wdata.ramp <= SCS_RAMP_MAX); // (R12) (R13)
    end

    // Time base in ms or s for the stage run times
    ms_tick = (r.ms_cnt == MS_LAST);
    n.ms_cnt = ms_tick ? '0 : r.ms_cnt + 1'h1;
    s_tick = ms_tick & (r.s_cnt == SCS_S_LAST);
    if (ms_tick) begin
      n.s_cnt = s_tick ? '0 : r.s_cnt + 1'h1;
    end
    unit_tick = r.unit ? s_tick : ms_tick;

    // Sequencer
    active = en && (r.src == SRC_MULTI); // (R5)
    last = ({1'h0, r.stage} + 5'h01) >= r.count;
    n.settle = 1'h0;
    unique case (r.st)
      ST_IDLE: begin
        if (active) begin
          n.st = ST_RUN;
          n.stage = (r.mode == MODE_TERM) ? term : '0; // (R6) (R9)
          n.elapsed = '0;
          n.settle = 1'h1;
        end
      end
      ST_RUN: begin
        if (r.mode == MODE_TERM) begin // (R3)
          if (term != r.stage) begin // (R10)
            n.stage = term; // (R10)
            n.settle = 1'h1;
          end
        end else if (!r.settle && r.elapsed >= cur_stage.run_time) begin // (R12)
          n.elapsed = '0;
          n.settle = 1'h1;
          if (!last) begin
            n.stage = r.stage + 1'h1; // (R6)
          end else if (r.mode == MODE_LOOP) begin
            n.stage = '0; // (R8)
          end else begin
            n.st = ST_DONE; // (R7)
          end
        end else if (unit_tick && r.elapsed != SCS_TIME_MAX) begin
          n.elapsed = r.elapsed + 1'h1;
        end
      end
      ST_DONE: begin
        n.st = ST_DONE; // (R7)
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    if (!active) begin // (R15)
      n.st = ST_IDLE;
      n.stage = '0;
      n.elapsed = '0;
      n.settle = 1'h0;
      n.ms_cnt = '0;
      n.s_cnt = '0;
    end

    // Command selection
    spd_b = (r.sec_src == SCS_SEC_SRC_DIGITAL) ? r.sec : scs_clamp(aux_ext_speed); // (R14)
    sum = {r.pri[SCS_SPD_W-1], r.pri} + {spd_b[SCS_SPD_W-1], spd_b}; // (R1)
    if (sum[SCS_SPD_W] != sum[SCS_SPD_W-1]) begin
      sum_sat = sum[SCS_SPD_W] ? SCS_SPD_MIN : SCS_SPD_MAX;
    end else begin
      sum_sat = scs_clamp(sum[SCS_SPD_W-1:0]);
    end
    n.cmd.ramp = '0;
    unique case (r.src)
      SRC_PRI: n.cmd.speed = r.pri; // (R1)
      SRC_SEC: n.cmd.speed = spd_b; // (R1)
      SRC_SWITCH: n.cmd.speed = sw ? spd_b : r.pri; // (R2)
      SRC_SUM: n.cmd.speed = sum_sat; // (R1)
      SRC_COMM: n.cmd.speed = r.comm; // (R14)
      SRC_MULTI: begin
        // Table output lags a stage change by one clock, so hold the speed and zero the ramp through it
        if (r.st == ST_RUN && !r.settle) begin
          n.cmd.speed = cur_stage.speed; // (R11)
          n.cmd.ramp = cur_stage.ramp; // (R13)
        end else if (r.st != ST_RUN) begin
          n.cmd.speed = '0; // (R7)
        end
      end
      default: n.cmd.speed = '0;
    endcase
    n.cmd.stage = r.stage;
    n.cmd.running = (r.st == ST_RUN) && (r.src == SRC_MULTI); // (R5)
    n.cmd.stopped = (r.st == ST_DONE) && (r.src == SRC_MULTI); // (R7)
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      r <= '0;
      r.src <= SRC_PRI;
      r.pri <= SCS_RST_PRI;
      r.sec_src <= SCS_RST_SEC_SRC;
      r.sec <= SCS_RST_SEC;
      r.comm <= SCS_RST_COMM;
      r.mode <= MODE_SINGLE; // (R4)
      r.count <= SCS_RST_COUNT;
      r.unit <= SCS_RST_UNIT;
      r.st <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign apb_rsp = r.rsp;
  assign cmd = r.cmd;

endmodule

// File: src/scs_stage_mem.sv
// Stage table: speed, run time and ramp set for each sequencer stage.
// Assumes a synchronised active-low reset; both read ports return data one clock after the address.
`timescale 1ns/100ps
module scs_stage_mem
  import scs_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic wr_speed,
  input logic wr_param,
  input logic [SCS_STG_W-1:0] waddr,
  input scs_stage_t wdata,
  input logic [SCS_STG_W-1:0] raddr_a,
  input logic [SCS_STG_W-1:0] raddr_b,
  output scs_stage_t rdata_a,
  output scs_stage_t rdata_b
);

  typedef struct packed {
    scs_stage_t [SCS_STAGES-1:0] mem;
    scs_stage_t rd_a;
    scs_stage_t rd_b;
  } scs_mem_st_t;

  scs_mem_st_t r;
  scs_mem_st_t n;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    n = r;
    // Speed and parameter words are written separately, so each keeps the other
    if (wr_speed) begin
      n.mem[waddr].speed = wdata.speed;
    end
    if (wr_param) begin
      n.mem[waddr].run_time = wdata.run_time;
      n.mem[waddr].ramp = wdata.ramp;
    end
    n.rd_a = r.mem[raddr_a];
    n.rd_b = r.mem[raddr_b];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SCS_STAGES; i++) begin
        r.mem[i] <= SCS_RST_STAGE;
      end
      r.rd_a <= SCS_RST_STAGE;
      r.rd_b <= SCS_RST_STAGE;
    end else begin
      r <= n;
    end
  end

  assign rdata_a = r.rd_a;
  assign rdata_b = r.rd_b;

endmodule
